// ==== rtl/osc_pkg.sv ====
package osc_pkg;

  // Oscillator configuration options, fixed at power-up
  typedef enum logic [1:0]
  {
    OSC_CFG_FAST_XTAL,
    OSC_CFG_EXT_RC,
    OSC_CFG_FAST_RC,
    OSC_CFG_FAST_RC_SLOW_XTAL
  } osc_cfg_e;

  typedef enum logic
  {
    OSC_INTERNAL_FAST_RC_OSC_4MHZ,
    OSC_INTERNAL_FAST_RC_OSC_8MHZ
  } osc_freq_e;

  localparam logic LXT_LP_RESET  = 1'h0;
  localparam logic CLKSEL_RESET  = 1'h0;
  localparam logic CLKSEL_FAST   = 1'h0;
  localparam logic CLKSEL_SLOW   = 1'h1;
  localparam logic LXT_MODE_QUICK = 1'h0;
  localparam logic LXT_MODE_LOWPWR = 1'h1;

  // Pin claim flags for the two oscillator-capable port lines
  typedef struct packed
  {
    logic line_six_is_osc;
    logic line_five_is_osc;
  } osc_pins_s;

  // Clock source status
  typedef struct packed
  {
    logic fast_rc_run;
    logic slow_xtal_run;
    logic fast_xtal_run;
    logic ext_rc_run;
    logic sysclk_from_slow;
  } osc_stat_s;

endpackage

// ==== rtl/osc_ctl.sv ====
// Function
// - Low-power bit selects quick-start or low-power
// - Low-power bit clears to zero at power-on
// - Slow clock runs normally in either mode
// - External RC claims line six only
// - Fast RC alone claims no pins
// - Slow crystal only with fast RC, both pins
// - Fast RC gives fixed 4 or 8 MHz
// - Clock select, combined option only: 0 fast RC, 1 slow crystal
`timescale 1ns/100ps
`default_nettype none

module osc_ctl
(
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire osc_pkg::osc_cfg_e  cfg_option,
  input  wire osc_pkg::osc_freq_e cfg_internal_fast_rc_osc_freq,
  input  wire logic             ctl_wr,
  input  wire logic             lxt_low_power_wdata,
  input  wire logic             sysclk_source_wdata,
  output logic                  lxt_low_power_sel,
  output logic                  sysclk_source_sel,
  output logic                  slow_xtal_bias_low,
  output logic                  slow_xtal_enable,
  output logic                  internal_fast_rc_osc_freq_8mhz,
  output osc_pkg::osc_pins_s    pin_claim,
  output osc_pkg::osc_stat_s    osc_status
);

  logic                 lxt_lp_q;
  logic                 clksel_q;
  osc_pkg::osc_cfg_e    cfg_q;
  osc_pkg::osc_freq_e   freq_q;
  logic                 slow_cfg;
  osc_pkg::osc_cfg_e    cfg_meta_q;
  osc_pkg::osc_cfg_e    cfg_sync_q;
  osc_pkg::osc_freq_e   freq_meta_q;
  osc_pkg::osc_freq_e   freq_sync_q;

  // Straps arrive from outside the clock domain; two stages first
  always_ff @(posedge mclk)
  begin
    cfg_meta_q  <= cfg_option;
    cfg_sync_q  <= cfg_meta_q;
    freq_meta_q <= cfg_internal_fast_rc_osc_freq;
    freq_sync_q <= freq_meta_q;
  end

  // Options latched at reset release; never change while running
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cfg_q  <= cfg_sync_q;
      freq_q <= freq_sync_q;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      lxt_lp_q <= osc_pkg::LXT_LP_RESET;
    end
    else if (ctl_wr)
    begin
      lxt_lp_q <= lxt_low_power_wdata;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      clksel_q <= osc_pkg::CLKSEL_RESET;
    end
    else if (ctl_wr)
    begin
      clksel_q <= sysclk_source_wdata;
    end
  end

  assign slow_cfg = (cfg_q == osc_pkg::OSC_CFG_FAST_RC_SLOW_XTAL);

  assign lxt_low_power_sel  = lxt_lp_q;
  assign sysclk_source_sel  = clksel_q;
  // Bias only; enable never depends on the low-power bit
  assign slow_xtal_bias_low = slow_cfg && (lxt_lp_q == osc_pkg::LXT_MODE_LOWPWR);
  assign slow_xtal_enable   = slow_cfg;
  assign internal_fast_rc_osc_freq_8mhz     = (freq_q == osc_pkg::OSC_INTERNAL_FAST_RC_OSC_8MHZ);

  always_comb
  begin
    pin_claim = '0;
    unique case (cfg_q)
      osc_pkg::OSC_CFG_FAST_XTAL:
      begin
        pin_claim.line_six_is_osc  = 1'h1;
        pin_claim.line_five_is_osc = 1'h1;
      end
      osc_pkg::OSC_CFG_EXT_RC:
      begin
        pin_claim.line_six_is_osc = 1'h1;
      end
      osc_pkg::OSC_CFG_FAST_RC:
      begin
        pin_claim = '0;
      end
      osc_pkg::OSC_CFG_FAST_RC_SLOW_XTAL:
      begin
        pin_claim.line_six_is_osc  = 1'h1;
        pin_claim.line_five_is_osc = 1'h1;
      end
    endcase
  end

  always_comb
  begin
    osc_status = '0;
    osc_status.fast_xtal_run = (cfg_q == osc_pkg::OSC_CFG_FAST_XTAL);
    osc_status.ext_rc_run    = (cfg_q == osc_pkg::OSC_CFG_EXT_RC);
    osc_status.slow_xtal_run = slow_cfg;
    // Select bit only honoured with the combined option
    osc_status.sysclk_from_slow = slow_cfg && (clksel_q == osc_pkg::CLKSEL_SLOW);
    osc_status.fast_rc_run = (cfg_q == osc_pkg::OSC_CFG_FAST_RC)
                             || (slow_cfg && (clksel_q == osc_pkg::CLKSEL_FAST));
  end

endmodule

`default_nettype wire

// ==== tb/osc_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
module osc_chk
(
  input wire logic mclk, rst, ctl_wr, lxt_low_power_wdata, sysclk_source_wdata,
  input wire logic lxt_low_power_sel, slow_xtal_bias_low, slow_xtal_enable,
  input wire osc_pkg::osc_cfg_e cfg_option,
  input wire osc_pkg::osc_pins_s pin_claim,
  input wire osc_pkg::osc_stat_s osc_status
);
  default clocking @(posedge mclk); endclocking
  default disable iff rst;
  a_lp_write:
    assert property (ctl_wr |=> lxt_low_power_sel == $past(lxt_low_power_wdata)) else $error("lp");
  a_lp_reset:
    assert property ($fell(rst) |-> !lxt_low_power_sel) else $error("lp reset");
  a_bias_map:
    assert property (slow_xtal_bias_low == (lxt_low_power_sel & slow_xtal_enable)) else $error("bias");
  a_en_steady:
    assert property (ctl_wr |=> $stable(slow_xtal_enable)) else $error("enable");
  a_rc_pins:
    assert property (cfg_option == osc_pkg::OSC_CFG_EXT_RC |-> pin_claim == 2'h2) else $error("rc");
  a_fast_pins:
    assert property (cfg_option == osc_pkg::OSC_CFG_FAST_RC |-> pin_claim == 2'h0) else $error("rc");
  a_slow_pins:
    assert property (slow_xtal_enable |-> pin_claim == 2'h3
      && cfg_option == osc_pkg::OSC_CFG_FAST_RC_SLOW_XTAL) else $error("slow pins");
  a_clk_sel:
    assert property (ctl_wr && slow_xtal_enable |=> osc_status.sysclk_from_slow
      == $past(sysclk_source_wdata) && osc_status.fast_rc_run != $past(sysclk_source_wdata))
      else $error("clk sel");
endmodule
bind osc_ctl osc_chk osc_chk_inst (.*);
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic mclk = 0, rst = 1, ctl_wr = 0, lp_w = 0, src_w = 0, lp, src, bias, en, f8, cmb;
  osc_pkg::osc_cfg_e cfg = osc_pkg::OSC_CFG_FAST_XTAL;
  osc_pkg::osc_freq_e fq = osc_pkg::OSC_INTERNAL_FAST_RC_OSC_4MHZ;
  osc_pkg::osc_pins_s pins;
  osc_pkg::osc_stat_s st;
  logic [1:0] pt [4] = '{2'h3, 2'h2, 2'h0, 2'h3};
  int n_errors = 0, compares = 0;
  osc_ctl osc_ctl_inst (.mclk(mclk), .rst(rst), .cfg_option(cfg), .cfg_internal_fast_rc_osc_freq(fq),
    .ctl_wr(ctl_wr), .lxt_low_power_wdata(lp_w), .sysclk_source_wdata(src_w),
    .lxt_low_power_sel(lp), .sysclk_source_sel(src), .slow_xtal_bias_low(bias),
    .slow_xtal_enable(en), .internal_fast_rc_osc_freq_8mhz(f8), .pin_claim(pins), .osc_status(st));
  initial forever #50 mclk = ~mclk;
  task automatic chk(string n, logic [1:0] e, logic [1:0] s);
    compares++;
    if (s !== e)
    begin
      $display("[ERR] %s exp %h got %h", n, e, s);
      n_errors++;
    end
  endtask
  task automatic wr(logic l, logic s);
    @(posedge mclk);
    ctl_wr <= 1; lp_w <= l; src_w <= s;
    @(posedge mclk);
    ctl_wr <= 0;
    #1;
  endtask
  task automatic test_done;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    for (int i = 0; i < 8; i++)
    begin
      @(posedge mclk);
      rst <= 1; cfg <= osc_pkg::osc_cfg_e'(i[1:0]); fq <= osc_pkg::osc_freq_e'(i[2]);
      cmb = (i[1:0] == 2'h3);
      wr(1, 1); // Write under reset must be ignored
      @(posedge mclk);
      rst <= 0;
      @(posedge mclk);
      #1;
      chk("lp", 0, lp);
      chk("pins", pt[i[1:0]], pins);
      chk("en", cmb, en);
      chk("f8", i[2], f8);
      chk("fxt", i[1:0] == 2'h0, st.fast_xtal_run);
      chk("erc", i[1:0] == 2'h1, st.ext_rc_run);
      chk("lxt", cmb, st.slow_xtal_run);
      wr(1, 1);
      chk("lp", 1, lp);
      chk("src", 1, src);
      chk("internal_fast_rc_osc", i[1:0] == 2'h2, st.fast_rc_run);
      chk("bias", cmb, bias);
      chk("slow", cmb, st.sysclk_from_slow);
      chk("en", cmb, en);
      wr(0, 0);
      chk("bias", 0, bias);
      chk("slow", 0, st.sysclk_from_slow);
      chk("src", 0, src);
      chk("internal_fast_rc_osc", (i[1:0] == 2'h2) || cmb, st.fast_rc_run);
      $display("test %0d done", i);
    end
    test_done();
  end
  initial
  begin
    #20000;
    n_errors++;
    test_done();
  end
endmodule
`default_nettype wire
